// [common/scl_pkg.sv]
// shared constants and carriers for the channel configuration latch bank
package scl_pkg;

  // ==========================================================================
  // geometry
  localparam int NUM_CH = 4;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int CFG_W  = 10;
  localparam int STAT_W = 6;
  localparam int MULT_W = 5;

  // ==========================================================================
  // register map, word indices (byte address = 4 * index)
  localparam logic [ADDR_W-1:0] CFG_BASE  = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_BASE = 4'h4;

  // ==========================================================================
  // per-channel configuration latches, bit 9 downward
  typedef struct packed {
    logic recenter_n;
    logic primary;
    logic secondary;
    logic tx_selftest_n;
    logic rx_selftest_n;
    logic rx_power_on;
    logic reframe;
    logic rate;
    logic clk_sel;
    logic enc_en;
  } scl_cfg_t;

  localparam scl_cfg_t CFG_RESET = 10'h26B;

  // byte lanes of the configuration word
  localparam int LANE0_LSB = 0;
  localparam int LANE1_LSB = 8;
  localparam int LANE1_W   = 2;

  // per-channel status word, bit 5 downward
  typedef struct packed {
    logic speed_sel;
    logic reserved_combo;
    logic recenter_pending;
    logic tx_logic_pd;
    logic secondary_pd;
    logic primary_pd;
  } scl_stat_t;

  // ==========================================================================
  // pll multipliers
  localparam logic [MULT_W-1:0] MULT_FULL = 5'h0A;
  localparam logic [MULT_W-1:0] MULT_DBL  = 5'h14;

  // ==========================================================================
  // pin carriers
  typedef struct packed {
    logic [7:0] data;
    logic [1:0] ctl;
  } scl_txword_t;

  typedef struct packed {
    logic                           dev_reset_n;
    logic        [NUM_CH-1:0]       ref_clk;
    logic        [NUM_CH-1:0]       tx_clk;
    logic        [NUM_CH-1:0]       speed;
    scl_txword_t [NUM_CH-1:0]       word;
  } scl_pins_t;

  localparam int PINS_W = $bits(scl_pins_t);

endpackage

// [rtl/scl_sync.sv]
// two-flop synchroniser for a bundle of asynchronous pins
`timescale 1ns/100ps
module scl_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } scl_sync_state_t;

  scl_sync_state_t state_reg;
  scl_sync_state_t state_next;

  // the first stage feeds only the second
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = d;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign q = state_reg.stable;

endmodule // scl_sync

// [rtl/scl_tx_capture.sv]
// one channel's transmit input register with selectable capture clock
`timescale 1ns/100ps
module scl_tx_capture (
  input  wire logic                clock,
  input  wire logic                rst,
  input  wire logic                ref_clk_s,
  input  wire logic                tx_clk_s,
  input  wire scl_pkg::scl_txword_t data_s,
  input  wire logic                clk_sel,
  input  wire logic                rate,
  output scl_pkg::scl_txword_t     word,
  output logic                     word_valid,
  output logic                     ref_level,
  output logic                     ref_edge,
  output logic                     tx_rise
);

  typedef struct packed {
    logic                 ref_d;
    logic                 tx_d;
    scl_pkg::scl_txword_t word;
    logic                 valid;
    logic                 ref_edge;
    logic                 tx_rise;
  } scl_cap_state_t;

  scl_cap_state_t state_reg;
  scl_cap_state_t state_next;

  always_comb begin
    logic rise_ref;
    logic fall_ref;
    logic rise_tx;
    logic take;
    take     = 1'b0;
    rise_ref = ref_clk_s & ~state_reg.ref_d;
    fall_ref = ~ref_clk_s & state_reg.ref_d;
    rise_tx  = tx_clk_s & ~state_reg.tx_d;
    if (clk_sel) begin
      take = rise_ref | (rate & fall_ref);
    end else begin
      take = rise_tx;
    end
    state_next          = state_reg;
    state_next.ref_d    = ref_clk_s;
    state_next.tx_d     = tx_clk_s;
    state_next.valid    = take;
    state_next.ref_edge = rise_ref | fall_ref;
    state_next.tx_rise  = rise_tx;
    if (take) begin
      state_next.word = data_s;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign word       = state_reg.word;
  assign word_valid = state_reg.valid;
  assign ref_level  = state_reg.ref_d;
  assign ref_edge   = state_reg.ref_edge;
  assign tx_rise    = state_reg.tx_rise;

endmodule // scl_tx_capture

// [rtl/scl_top.sv]
// four-channel transceiver configuration latch bank with avalon-mm access
// ============================================================================
// Notes on behaviour
// - encoder enable resets to 1; 0 sends raw ten-bit characters.
// - clock select 1 (reset) loads input on reference rise, bypasses phase buffer.
// - clock select 0 captures data and control on transmit input clock rise.
// - rate resets to 0: multiply by 10, output clock follows reference.
// - rate 1 multiplies by 20, output clock at twice reference frequency.
// - select 1 with rate 1 captures on both reference edges.
// - reframe enable resets to 1; 0 freezes the frame offset.
// - receive power-on resets to 0 (powered down); 1 powers up.
// - receive self-test latch active low, resets to 1 (off).
// - transmit self-test latch active low, resets to 1 (off).
// - secondary driver enable resets to 0; 1 drives shifter data.
// - primary driver enable resets to 0; 1 drives shifter data.
// - disabled driver powers down; both disabled powers down transmit logic.
// - device reset pin low disables every driver on all channels.
// - recentre latch resets to 1; writing 0 re-centres phase buffer.
// - recentre request is taken on a transmit input clock rise.
// - recentre latch clears itself back to 1 after use.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
module scl_top (
  input  wire logic                                          clock,
  input  wire logic                                          rst,
  // avalon-mm slave
  input  wire logic [scl_pkg::ADDR_W-1:0]                    avs_address,
  input  wire logic                                          avs_read,
  input  wire logic                                          avs_write,
  input  wire logic [scl_pkg::DATA_W-1:0]                    avs_writedata,
  input  wire logic [3:0]                                    avs_byteenable,
  output logic      [scl_pkg::DATA_W-1:0]                    avs_readdata,
  output logic                                               avs_waitrequest,
  // pins
  input  wire logic                                          device_reset_n,
  input  wire logic [scl_pkg::NUM_CH-1:0]                    channel_reference_clock,
  input  wire logic [scl_pkg::NUM_CH-1:0]                    tx_input_clock,
  input  wire logic [scl_pkg::NUM_CH-1:0]                    speed_range_select,
  input  wire logic [scl_pkg::NUM_CH-1:0][7:0]               tx_data_in,
  input  wire logic [scl_pkg::NUM_CH-1:0][1:0]               tx_control_in,
  // transmit path
  output scl_pkg::scl_txword_t [scl_pkg::NUM_CH-1:0]         tx_word,
  output logic      [scl_pkg::NUM_CH-1:0]                    tx_word_valid,
  output logic      [scl_pkg::NUM_CH-1:0]                    tx_output_clock,
  output logic      [scl_pkg::NUM_CH-1:0][scl_pkg::MULT_W-1:0] tx_pll_multiplier,
  output logic      [scl_pkg::NUM_CH-1:0]                    tx_encoder_enable,
  output logic      [scl_pkg::NUM_CH-1:0]                    phase_buffer_bypass,
  output logic      [scl_pkg::NUM_CH-1:0]                    phase_buffer_recenter,
  // receive path and self-test enables
  output logic      [scl_pkg::NUM_CH-1:0]                    reframe_enable,
  output logic      [scl_pkg::NUM_CH-1:0]                    rx_channel_power_on,
  output logic      [scl_pkg::NUM_CH-1:0]                    rx_selftest_on,
  output logic      [scl_pkg::NUM_CH-1:0]                    tx_selftest_on,
  // serial drivers
  output logic      [scl_pkg::NUM_CH-1:0]                    primary_driver_enable,
  output logic      [scl_pkg::NUM_CH-1:0]                    secondary_driver_enable,
  output logic      [scl_pkg::NUM_CH-1:0]                    primary_driver_power_down,
  output logic      [scl_pkg::NUM_CH-1:0]                    secondary_driver_power_down,
  output logic      [scl_pkg::NUM_CH-1:0]                    tx_logic_power_down
);

  localparam int N = scl_pkg::NUM_CH;

  // ==========================================================================
  // state
  typedef struct packed {
    scl_pkg::scl_cfg_t [N-1:0]          cfg;
    logic [N-1:0]                       txo;
    logic [N-1:0][scl_pkg::MULT_W-1:0]  mult;
    logic [N-1:0]                       enc;
    logic [N-1:0]                       bypass;
    logic [N-1:0]                       recenter;
    logic [N-1:0]                       reframe;
    logic [N-1:0]                       rx_power;
    logic [N-1:0]                       rx_st;
    logic [N-1:0]                       tx_st;
    logic [N-1:0]                       pen;
    logic [N-1:0]                       sen;
    logic [N-1:0]                       ppd;
    logic [N-1:0]                       spd;
    logic [N-1:0]                       tpd;
    logic                               waitreq;
    logic [scl_pkg::DATA_W-1:0]         rdata;
  } scl_state_t;

  scl_state_t state_reg;
  scl_state_t state_next;

  // ==========================================================================
  // pin synchronisers and per-channel input registers
  scl_pkg::scl_pins_t                pins_raw;
  scl_pkg::scl_pins_t                pins_s;
  logic [scl_pkg::PINS_W-1:0]        pins_q;
  logic [N-1:0]                      ref_level;
  logic [N-1:0]                      ref_edge;
  logic [N-1:0]                      tx_rise;

  always_comb begin
    pins_raw             = '0;
    pins_raw.dev_reset_n = device_reset_n;
    pins_raw.ref_clk     = channel_reference_clock;
    pins_raw.tx_clk      = tx_input_clock;
    pins_raw.speed       = speed_range_select;
    for (int c = 0; c < N; c++) begin
      pins_raw.word[c].data = tx_data_in[c];
      pins_raw.word[c].ctl  = tx_control_in[c];
    end
  end

  // data pins are synchronised too; the captured word is only valid when the
  // host holds it stable around the chosen clock edge
  scl_sync #(
    .W (scl_pkg::PINS_W)
  ) u_sync (
    .clock (clock),
    .rst   (rst),
    .d     (pins_raw),
    .q     (pins_q)
  );

  assign pins_s = pins_q;

  for (genvar g = 0; g < N; g++) begin : g_ch
    scl_tx_capture u_cap (
      .clock      (clock),
      .rst        (rst),
      .ref_clk_s  (pins_s.ref_clk[g]),
      .tx_clk_s   (pins_s.tx_clk[g]),
      .data_s     (pins_s.word[g]),
      .clk_sel    (state_reg.cfg[g].clk_sel),
      .rate       (state_reg.cfg[g].rate),
      .word       (tx_word[g]),
      .word_valid (tx_word_valid[g]),
      .ref_level  (ref_level[g]),
      .ref_edge   (ref_edge[g]),
      .tx_rise    (tx_rise[g])
    );
  end

  // ==========================================================================
  // helpers
  function automatic scl_pkg::scl_cfg_t merge_cfg(
    input scl_pkg::scl_cfg_t          old,
    input logic [scl_pkg::DATA_W-1:0] wd,
    input logic [3:0]                 be
  );
    scl_pkg::scl_cfg_t res;
    res = old;
    if (be[0]) begin
      res[scl_pkg::LANE0_LSB +: 8] = wd[scl_pkg::LANE0_LSB +: 8];
    end
    if (be[1]) begin
      res[scl_pkg::LANE1_LSB +: scl_pkg::LANE1_W] = wd[scl_pkg::LANE1_LSB +: scl_pkg::LANE1_W];
    end
    return res;
  endfunction

  function automatic scl_pkg::scl_stat_t status_of(
    input scl_pkg::scl_cfg_t cfg,
    input logic              speed
  );
    scl_pkg::scl_stat_t st;
    st.speed_sel        = speed;
    // flags a setting the host was told never to make
    st.reserved_combo   = cfg.rate & ~speed;
    st.recenter_pending = ~cfg.recenter_n;
    st.tx_logic_pd      = ~cfg.primary & ~cfg.secondary;
    st.secondary_pd     = ~cfg.secondary;
    st.primary_pd       = ~cfg.primary;
    return st;
  endfunction

  // ==========================================================================
  // next state
  always_comb begin
    logic                       req;
    logic [1:0]                 idx;
    logic [scl_pkg::DATA_W-1:0] rd;
    req        = avs_read | avs_write;
    idx        = avs_address[1:0];
    rd         = '0;
    state_next = state_reg;

    // a recentre request waits for the transmit input clock, then clears itself
    for (int c = 0; c < N; c++) begin
      if (!state_reg.cfg[c].recenter_n && tx_rise[c]) begin
        state_next.cfg[c].recenter_n = 1'b1;
      end
    end

    // one wait state: look at the request, answer on the next edge
    if (req && state_reg.waitreq) begin
      if (avs_address[3:2] == scl_pkg::CFG_BASE[3:2]) begin
        rd[scl_pkg::CFG_W-1:0] = state_reg.cfg[idx];
      end else if (avs_address[3:2] == scl_pkg::STAT_BASE[3:2]) begin
        rd[scl_pkg::STAT_W-1:0] = status_of(state_reg.cfg[idx], pins_s.speed[idx]);
      end
      state_next.waitreq = 1'b0;
      state_next.rdata   = rd;
    end else if (req) begin
      state_next.waitreq = 1'b1;
      // only the addressed channel changes; a new write of 0 wins over self-clear
      if (avs_write && avs_address[3:2] == scl_pkg::CFG_BASE[3:2]) begin
        state_next.cfg[idx] = merge_cfg(state_reg.cfg[idx], avs_writedata,
                                        avs_byteenable);
      end
    end else begin
      state_next.waitreq = 1'b1;
    end

    // device reset pin returns every latch to its default, drivers off
    if (!pins_s.dev_reset_n) begin
      for (int c = 0; c < N; c++) begin
        state_next.cfg[c] = scl_pkg::CFG_RESET;
      end
    end

    // derived outputs, registered so each port leaves a flip-flop
    for (int c = 0; c < N; c++) begin
      state_next.enc[c]      = state_next.cfg[c].enc_en;
      state_next.bypass[c]   = state_next.cfg[c].clk_sel;
      state_next.reframe[c]  = state_next.cfg[c].reframe;
      state_next.rx_power[c] = state_next.cfg[c].rx_power_on;
      state_next.rx_st[c]    = ~state_next.cfg[c].rx_selftest_n;
      state_next.tx_st[c]    = ~state_next.cfg[c].tx_selftest_n;
      state_next.sen[c]      = state_next.cfg[c].secondary;
      state_next.pen[c]      = state_next.cfg[c].primary;
      state_next.spd[c]      = ~state_next.cfg[c].secondary;
      state_next.ppd[c]      = ~state_next.cfg[c].primary;
      state_next.tpd[c]      = ~state_next.cfg[c].primary & ~state_next.cfg[c].secondary;
      state_next.recenter[c] = !state_reg.cfg[c].recenter_n && tx_rise[c];
      if (state_next.cfg[c].rate) begin
        state_next.mult[c] = scl_pkg::MULT_DBL;
        // a high pulse per reference edge doubles the frequency
        state_next.txo[c]  = ref_edge[c];
      end else begin
        state_next.mult[c] = scl_pkg::MULT_FULL;
        state_next.txo[c]  = ref_level[c];
      end
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg          <= '0;
      state_reg.cfg      <= {N{scl_pkg::CFG_RESET}};
      state_reg.enc      <= '1;
      state_reg.bypass   <= '1;
      state_reg.reframe  <= '1;
      state_reg.mult     <= {N{scl_pkg::MULT_FULL}};
      state_reg.ppd      <= '1;
      state_reg.spd      <= '1;
      state_reg.tpd      <= '1;
      state_reg.waitreq  <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // outputs
  assign avs_readdata                = state_reg.rdata;
  assign avs_waitrequest             = state_reg.waitreq;
  assign tx_output_clock             = state_reg.txo;
  assign tx_pll_multiplier           = state_reg.mult;
  assign tx_encoder_enable           = state_reg.enc;
  assign phase_buffer_bypass         = state_reg.bypass;
  assign phase_buffer_recenter       = state_reg.recenter;
  assign reframe_enable              = state_reg.reframe;
  assign rx_channel_power_on         = state_reg.rx_power;
  assign rx_selftest_on              = state_reg.rx_st;
  assign tx_selftest_on              = state_reg.tx_st;
  assign primary_driver_enable       = state_reg.pen;
  assign secondary_driver_enable     = state_reg.sen;
  assign primary_driver_power_down   = state_reg.ppd;
  assign secondary_driver_power_down = state_reg.spd;
  assign tx_logic_power_down         = state_reg.tpd;

endmodule // scl_top

// [verif/scl_top_asserts.sv]
// port-level checks for the channel configuration latch bank
`timescale 1ns/100ps
module scl_top_asserts (
  input logic            clock,
  input logic            rst,
  input logic            avs_read,
  input logic            avs_write,
  input logic            avs_waitrequest,
  input logic            device_reset_n,
  input logic [3:0]      channel_reference_clock,
  input logic [3:0]      tx_input_clock,
  input logic [3:0][7:0] tx_data_in,
  input logic [3:0][1:0] tx_control_in,
  input logic [3:0][9:0] tx_word,
  input logic [3:0]      tx_word_valid,
  input logic [3:0]      tx_output_clock,
  input logic [3:0][4:0] tx_pll_multiplier,
  input logic [3:0]      phase_buffer_bypass,
  input logic [3:0]      phase_buffer_recenter,
  input logic [3:0]      primary_driver_enable,
  input logic [3:0]      secondary_driver_enable,
  input logic [3:0]      primary_driver_power_down,
  input logic [3:0]      secondary_driver_power_down,
  input logic [3:0]      tx_logic_power_down
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ==========================================================================
  // register bus
  property p_answer;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("waitrequest low too long");

  // ==========================================================================
  // channel 0 transmit path; the bench keeps clocks still while it reconfigures
  property p_ref_capture;
    phase_buffer_bypass[0] && ($rose(channel_reference_clock[0]) ||
      (tx_pll_multiplier[0] == scl_pkg::MULT_DBL && $fell(channel_reference_clock[0])))
      |-> ##[1:4] tx_word_valid[0];
  endproperty
  a_ref_capture: assert property (p_ref_capture) else $error("no capture on ref edge");
  property p_tx_capture;
    !phase_buffer_bypass[0] && $rose(tx_input_clock[0]) |-> ##[1:4] tx_word_valid[0];
  endproperty
  a_tx_capture: assert property (p_tx_capture) else $error("no capture on tx clock");
  property p_word;
    tx_word_valid[0] |-> tx_word[0] == {$past(tx_data_in[0], 3), $past(tx_control_in[0], 3)};
  endproperty
  a_word: assert property (p_word) else $error("captured word differs from pins");
  property p_full_rate;
    tx_pll_multiplier[0] == scl_pkg::MULT_FULL && $rose(channel_reference_clock[0])
      |-> ##[1:4] $rose(tx_output_clock[0]);
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("output clock not following ref");
  property p_double_rate;
    tx_pll_multiplier[0] == scl_pkg::MULT_DBL && $changed(channel_reference_clock[0])
      |-> ##[1:4] tx_output_clock[0];
  endproperty
  a_double_rate: assert property (p_double_rate) else $error("no output pulse per ref edge");
  property p_recenter;
    phase_buffer_recenter[0] |-> tx_input_clock[0] ##1 !phase_buffer_recenter[0];
  endproperty
  a_recenter: assert property (p_recenter) else $error("recentre pulse misplaced");

  // ==========================================================================
  // serial drivers
  property p_power_down;
    primary_driver_power_down == ~primary_driver_enable &&
      secondary_driver_power_down == ~secondary_driver_enable &&
      tx_logic_power_down == (~primary_driver_enable & ~secondary_driver_enable);
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down mismatch");
  property p_dev_reset;
    !device_reset_n [*5] |-> primary_driver_enable == '0 && secondary_driver_enable == '0;
  endproperty
  a_dev_reset: assert property (p_dev_reset) else $error("drivers on during pin reset");
endmodule // scl_top_asserts

// [verif/scl_pin_source.sv]
// far-side pin source: reference and transmit clocks with parallel data
`timescale 1ns/100ps
module scl_pin_source (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       en,
  output logic [3:0]      ref_clk,
  output logic [3:0]      tx_clk,
  output logic [3:0][7:0] data,
  output logic [3:0][1:0] ctl
);
  logic [3:0] cnt_reg = 4'hF;

  // clocks stand still low at count 15, so a stop never cuts a pulse short
  assign ref_clk = {4{cnt_reg < 4'h8}};
  assign tx_clk = {4{cnt_reg >= 4'h2 && cnt_reg < 4'hA}};

  always @(posedge clock) begin
    if (rst || (!en && cnt_reg == 4'hF)) begin
      cnt_reg <= 4'hF;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
    // data moves midway between edges; while idle it churns every cycle
    if (cnt_reg == 4'h4 || cnt_reg == 4'hC || (!en && cnt_reg == 4'hF)) begin
      data <= $urandom;
      ctl <= 8'($urandom);
    end
  end
endmodule // scl_pin_source

// [verif/scl_top_tb_top.sv]
// self-checking bench for the channel configuration latch bank
`timescale 1ns/100ps
module scl_top_tb_top;
  logic clock, rst, avs_read, avs_write, avs_waitrequest, device_reset_n, src_en, oclk_q;
  logic [3:0]  avs_address, avs_byteenable, speed_range_select;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  channel_reference_clock, tx_input_clock, tx_word_valid, tx_output_clock;
  logic [3:0]  tx_encoder_enable, phase_buffer_bypass, phase_buffer_recenter, reframe_enable;
  logic [3:0]  rx_channel_power_on, rx_selftest_on, tx_selftest_on, primary_driver_enable;
  logic [3:0]  secondary_driver_enable, primary_driver_power_down, secondary_driver_power_down;
  logic [3:0]  tx_logic_power_down;
  logic [3:0][7:0] tx_data_in;
  logic [3:0][1:0] tx_control_in;
  logic [3:0][4:0] tx_pll_multiplier;
  scl_pkg::scl_txword_t [3:0] tx_word;
  scl_pkg::scl_cfg_t cfg_m [4];
  int n_mismatch, checked, n_valid, n_oclk, n_rec, seed_q;
  logic [9:0] mode_v [4] = '{10'h26B, 10'h26F, 10'h269, 10'h26D};
  int exp_v [4] = '{4, 8, 4, 4};
  int exp_o [4] = '{4, 8, 4, 8};

  scl_top dut_u (.*);
  scl_pin_source src_u (.clock, .rst, .en(src_en), .ref_clk(channel_reference_clock),
    .tx_clk(tx_input_clock), .data(tx_data_in), .ctl(tx_control_in));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    if (tx_word_valid[0] === 1'b1) n_valid++;
    if (tx_output_clock[0] === 1'b1 && oclk_q === 1'b0) n_oclk++;
    if (phase_buffer_recenter[0] === 1'b1) n_rec++;
    oclk_q = tx_output_clock[0];
  end

  // ==========================================================================
  // helpers
  task automatic complete_run;
    $display("checks %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: bus request hung", $time);
      complete_run();
    end
  endtask

  task automatic wr_cfg(input int ch, input logic [31:0] d, input logic [3:0] be);
    bus(1'b1, ch[3:0], d, be);
    if (be[0]) cfg_m[ch][7:0] = d[7:0];
    if (be[1]) cfg_m[ch][9:8] = d[9:8];
  endtask

  function automatic logic [15:0] exp_out(input scl_pkg::scl_cfg_t c);
    return {c.enc_en, c.clk_sel, c.reframe, c.rx_power_on, ~c.rx_selftest_n, ~c.tx_selftest_n,
            c.primary, c.secondary, ~c.primary, ~c.secondary, ~c.primary & ~c.secondary,
            c.rate ? scl_pkg::MULT_DBL : scl_pkg::MULT_FULL};
  endfunction

  task automatic check_all;
    for (int c = 0; c < 4; c++) begin
      bus(1'b0, c[3:0], 32'h0, 4'hF);
      check(rd, {22'h0, cfg_m[c]}, "config readback");
    end
    @(negedge clock);
    for (int c = 0; c < 4; c++) begin
      check({16'h0, tx_encoder_enable[c], phase_buffer_bypass[c], reframe_enable[c],
             rx_channel_power_on[c], rx_selftest_on[c], tx_selftest_on[c],
             primary_driver_enable[c], secondary_driver_enable[c], primary_driver_power_down[c],
             secondary_driver_power_down[c], tx_logic_power_down[c], tx_pll_multiplier[c]},
            {16'h0, exp_out(cfg_m[c])}, "channel levels");
    end
  endtask

  // four full clock periods, then wait for the last capture to land
  task automatic run_window;
    @(negedge clock);
    n_valid = 0;
    n_oclk = 0;
    n_rec = 0;
    @(posedge clock);
    src_en <= 1'b1;
    repeat (64) @(posedge clock);
    src_en <= 1'b0;
    repeat (12) @(posedge clock);
    @(negedge clock);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    n_mismatch = 0;
    checked = 0;
    src_en = 1'b0;
    oclk_q = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    device_reset_n = 1'b1;
    speed_range_select = 4'hF;
    rst = 1'b1;
    seed_q = $urandom(57367);
    cfg_m = '{default: scl_pkg::CFG_RESET};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    check_all();
    $display("reset values done");
    // random lanes and channels; recentre bit held at 1
    repeat (12) wr_cfg($urandom_range(3), $urandom | 32'h200, 4'($urandom));
    check_all();
    $display("random writes done");
    bus(1'b1, {1'b1, 3'($urandom)}, $urandom, 4'hF);
    bus(1'b0, 4'hC, 32'h0, 4'hF);
    check(rd, 32'h0, "unmapped read");
    bus(1'b1, 4'h5, 32'h3FF, 4'hF);
    check_all();
    $display("refused writes done");
    for (int m = 0; m < 4; m++) begin
      wr_cfg(0, {22'h0, mode_v[m]}, 4'hF);
      run_window();
      check(n_valid, exp_v[m], "capture count");
      check(n_oclk, exp_o[m], "output clock rises");
    end
    check_all();
    $display("capture modes done");
    wr_cfg(0, 32'h069, 4'hF);
    bus(1'b0, 4'h0, 32'h0, 4'hF);
    check(rd, 32'h069, "recentre pending");
    bus(1'b0, 4'h4, 32'h0, 4'hF);
    check(rd, 32'h2F, "status");
    run_window();
    check(n_rec, 1, "recentre pulses");
    cfg_m[0].recenter_n = 1'b1;
    check_all();
    $display("recentre done");
    for (int c = 0; c < 4; c++) wr_cfg(c, 32'h3EB, 4'hF);
    check_all();
    @(posedge clock);
    device_reset_n <= 1'b0;
    repeat (8) @(posedge clock);
    device_reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    cfg_m = '{default: scl_pkg::CFG_RESET};
    check_all();
    $display("pin reset done");
    complete_run();
  end
endmodule // scl_top_tb_top

bind scl_top scl_top_asserts chk_u (.clock, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .device_reset_n, .channel_reference_clock, .tx_input_clock, .tx_data_in, .tx_control_in,
  .tx_word, .tx_word_valid, .tx_output_clock, .tx_pll_multiplier, .phase_buffer_bypass,
  .phase_buffer_recenter, .primary_driver_enable, .secondary_driver_enable,
  .primary_driver_power_down, .secondary_driver_power_down, .tx_logic_power_down);
